// ### verilog/fcx_pkg.sv
// Shared constants and types for the trunk speed and transceiver data block.
package fcx_pkg;

  // Command and response packet type codes.
  localparam logic [7:0] FCX_CMD_CODE = 8'h32;
  localparam logic [7:0] FCX_RSP_CODE = 8'hB2;

  // Register byte offsets on the APB side.
  localparam logic [7:0] FCX_OFF_CTRL = 8'h00;
  localparam logic [7:0] FCX_OFF_REQ = 8'h04;
  localparam logic [7:0] FCX_OFF_LCFG = 8'h08;
  localparam logic [7:0] FCX_OFF_MCFG = 8'h0C;
  localparam logic [7:0] FCX_OFF_STAT = 8'h10;
  localparam logic [7:0] FCX_OFF_RESP = 8'h14;
  localparam logic [7:0] FCX_OFF_HDR = 8'h18;
  localparam logic [7:0] FCX_OFF_LINK = 8'h1C;
  localparam logic [7:0] FCX_OFF_LSPD = 8'h20;
  localparam int FCX_DATA_BIT = 7;

  // Control register fields.
  localparam int FCX_CTRL_GO = 0;
  localparam int FCX_CTRL_NOSUP = 1;
  localparam int FCX_CTRL_CMD_LSB = 8;
  localparam int FCX_FLAG_UPPER = 0;

  // Response and reason codes.
  localparam logic [15:0] FCX_RSP_OK = 16'h0000;
  localparam logic [15:0] FCX_RSP_FAILED = 16'h0001;
  localparam logic [15:0] FCX_RSP_UNAVAIL = 16'h0002;
  localparam logic [15:0] FCX_RSP_UNSUP = 16'h0003;
  localparam logic [15:0] FCX_RSN_NONE = 16'h0000;
  localparam logic [15:0] FCX_RSN_RANGE = 16'h0002;
  localparam logic [15:0] FCX_RSN_UNSUP_CMD = 16'h0003;
  localparam logic [15:0] FCX_RSN_NOT_AVAIL = 16'h0005;
  localparam logic [15:0] FCX_RSN_TIMEOUT = 16'h0006;

  // Trunk percentage and link speed codes.
  localparam logic [3:0] FCX_PCT_0 = 4'h0;
  localparam logic [3:0] FCX_PCT_50 = 4'h2;
  localparam logic [3:0] FCX_PCT_100 = 4'h4;
  localparam logic [3:0] FCX_SPD_NONE = 4'h0;
  localparam logic [3:0] FCX_SPD_MAX = 4'h8;
  localparam logic [3:0] FCX_MAX_PORTS = 4'h4;

  // Module block geometry.
  localparam int FCX_BLK_BYTES = 128;
  localparam logic [7:0] FCX_UPPER_BASE = 8'h80;
  localparam logic [7:0] FCX_STATIC_PAGE = 8'h00;
  localparam logic [7:0] FCX_STATIC_BANK = 8'h00;

  // Time the module gets to deliver one whole block.
  localparam int FCX_CLK_PERIOD_NS = 50;
  localparam int FCX_XRD_TIMEOUT_NS = 10000000;
  localparam int FCX_XRD_TIMEOUT_CYC = FCX_XRD_TIMEOUT_NS / FCX_CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] bank;
    logic [7:0] page;
    logic [7:0] rsvd;
    logic [7:0] flags;
  } fcx_req_t;

  typedef struct packed {
    logic [7:0] max_bank;
    logic [7:0] max_page;
    logic [7:0] bank;
    logic [7:0] page;
  } fcx_hdr_t;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] reason;
  } fcx_resp_t;

  typedef struct packed {
    logic [7:0] num_ports;
    logic [7:0] trunk_status;
    logic [7:0] link_status;
    logic [7:0] trunk_speeds;
  } fcx_link_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [3:0] speed;
    logic [3:0] channels;
    logic [3:0] ports;
  } fcx_lcfg_t;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0] max_page;
    logic [7:0] max_bank;
  } fcx_mcfg_t;

  typedef struct packed {
    logic [7:0] bank;
    logic [7:0] page;
    logic [7:0] offset;
  } fcx_mrd_t;

endpackage

// ### verilog/fcx_link_calc.sv
// Link status, trunk percentage and configured speed computation.
module fcx_link_calc import fcx_pkg::*; (
  input wire fcx_lcfg_t cfg, // Port, channel and per-port speed setup
  input wire logic [3:0] link_up, // Per-port link state, high is up
  output fcx_link_t link, // Link status response word
  output logic [3:0] speed // Reported channel link speed code
);

  function automatic logic [3:0] pct_pair(input logic [1:0] up);
    case (up)
      2'b11: pct_pair = FCX_PCT_100;
      2'b01, 2'b10: pct_pair = FCX_PCT_50;
      default: pct_pair = FCX_PCT_0;
    endcase
  endfunction

  // A trunk of n links runs n times one port, one code step per doubling.
  function automatic logic [3:0] spd_up(input logic [3:0] s,
                                        input logic [3:0] steps);
    logic [4:0] sum;
    sum = {1'b0, s} + {1'b0, steps};
    if (s == FCX_SPD_NONE)
      spd_up = FCX_SPD_NONE;
    else if (sum > {1'b0, FCX_SPD_MAX})
      spd_up = FCX_SPD_MAX;
    else
      spd_up = sum[3:0];
  endfunction

  logic [3:0] mask;
  logic [3:0] up;

  always_comb begin
    case (cfg.ports)
      4'h1: mask = 4'h1;
      4'h2: mask = 4'h3;
      4'h3: mask = 4'h7;
      4'h4: mask = 4'hF;
      default: mask = 4'h0;
    endcase
    up = link_up & mask;
    link = '0;
    link.num_ports = {4'h0, cfg.ports};
    link.link_status = {4'h0, up};
    speed = cfg.speed;
    if (cfg.ports == cfg.channels) begin
      link.trunk_status = '0;
    end else if (cfg.ports == {cfg.channels[2:0], 1'b0}) begin
      link.trunk_status = {4'h0, mask};
      link.trunk_speeds[3:0] = pct_pair(up[1:0]);
      if (cfg.ports == FCX_MAX_PORTS)
        link.trunk_speeds[7:4] = pct_pair(up[3:2]);
      speed = spd_up(cfg.speed, 4'h1);
    end else if (cfg.ports == {cfg.channels[1:0], 2'b00}) begin
      link.trunk_status = {4'h0, mask};
      // A plain sum of one-bit flags would wrap at one bit, so count them.
      link.trunk_speeds[3:0] = 4'($countones(up));
      speed = spd_up(cfg.speed, 4'h2);
    end
  end

endmodule

// ### verilog/fcx_xrd.sv
// Reads one 128-byte block from the transceiver module, with a time limit.
module fcx_xrd import fcx_pkg::*; #(
  parameter int TIMEOUT_CYC = FCX_XRD_TIMEOUT_CYC
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic start, // One-cycle pulse starting a block read
  input wire fcx_mrd_t base, // Bank, page and first offset
  output logic mod_rd_req, // Byte request to the module, held until ack
  output fcx_mrd_t mod_rd_addr, // Address of the requested byte
  input wire logic mod_rd_ack, // Module returns the byte this cycle
  input wire logic [7:0] mod_rd_data, // Returned byte
  output logic wr_en, // Pulse: buffer byte write
  output logic [6:0] wr_idx, // Buffer byte index
  output logic [7:0] wr_data, // Buffer byte value
  output logic done, // Pulse: whole block delivered
  output logic timeout // Pulse: module missed the time limit
);

  typedef enum logic {X_IDLE, X_REQ} fcx_xst_t;

  typedef struct packed {
    fcx_xst_t st;
    fcx_mrd_t addr;
    logic [6:0] idx;
    logic [31:0] timer;
    logic wr_en;
    logic [6:0] wr_idx;
    logic [7:0] wr_data;
    logic done;
    logic timeout;
  } fcx_xrd_state_t;

  fcx_xrd_state_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.wr_en = 1'b0;
    next_s.done = 1'b0;
    next_s.timeout = 1'b0;
    case (s.st)
      X_IDLE: begin
        if (start) begin
          next_s.st = X_REQ;
          next_s.addr = base;
          next_s.idx = '0;
          next_s.timer = '0;
        end
      end
      X_REQ: begin
        next_s.timer = s.timer + 32'h1;
        if (mod_rd_ack) begin
          next_s.wr_en = 1'b1;
          next_s.wr_idx = s.idx;
          next_s.wr_data = mod_rd_data;
          next_s.idx = s.idx + 7'h1;
          next_s.addr.offset = s.addr.offset + 8'h1;
          if (s.idx == 7'h7F) begin
            next_s.st = X_IDLE;
            next_s.done = 1'b1;
          end
        end else if (s.timer >= 32'(TIMEOUT_CYC - 1)) begin
          next_s.st = X_IDLE;
          next_s.timeout = 1'b1;
        end
      end
      default: next_s.st = X_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign mod_rd_req = (s.st == X_REQ);
  assign mod_rd_addr = s.addr;
  assign wr_en = s.wr_en;
  assign wr_idx = s.wr_idx;
  assign wr_data = s.wr_data;
  assign done = s.done;
  assign timeout = s.timeout;

endmodule

// ### verilog/fcx_top.sv
// Trunk speed reporting and transceiver data command engine with APB access.
//
// Operation
// - Trunk one percentage in bits 3:0, codes 0 to 4 in 25% steps.
// - Trunk two percentage in bits 7:4, codes for 0, 50, 100% only.
// - Ports equal to channels means no trunking; report own port speed.
// - Two or four port trunks report the summed member link speed.
// - Failed members leave speed unchanged; flags and percentages show it.
// - Speed code 0 means none, 1 to 8 cover 2G to 256G.
// - A data request returns one 128-byte block from the module.
// - A single-bank module only ever returns data tagged bank 0.
// - Upper half of page 0 may be read once and served from cache.
// - Backplane and copper jack builds reject the command as unsupported.
// - Flags bit 0 picks lower or upper half; bits 7:1 are reserved.
// - Without error, command 0x32 is answered with response 0xB2.
// - No module installed gives command unavailable, info not available.
// - Missing bank or page gives command failed, parameter out of range.
// - Module resetting gives command failed, information not available.
// - Module too slow gives command failed with a timeout reason.
// - Response carries max bank, max page, bank, page, then the data.
// - Max bank is the highest module bank, zero without banks.
// - Max page is the highest page in the current bank.
// - Bank and page bytes echo the requested values.
// - Link status bits 0 to 3 show each port's link, set is up.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
module fcx_top import fcx_pkg::*; #(
  parameter int TIMEOUT_CYC = FCX_XRD_TIMEOUT_CYC
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [7:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high is write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB transfer complete
  output logic pslverr, // APB error for unmapped register address or data write
  input wire logic [3:0] port_link_up, // Physical port link states
  input wire logic mod_present, // Transceiver module is installed
  input wire logic mod_ready, // Module finished reset and power up
  output logic mod_rd_req, // Byte read request to the module
  output fcx_mrd_t mod_rd_addr, // Bank, page and byte offset
  input wire logic mod_rd_ack, // Module delivers the requested byte
  input wire logic [7:0] mod_rd_data // Byte from the module
);

  typedef enum logic {M_IDLE, M_READ} fcx_mst_t;

  typedef struct packed {
    fcx_mst_t st;
    logic nosup;
    fcx_lcfg_t lcfg;
    fcx_mcfg_t mcfg;
    fcx_req_t req;
    fcx_resp_t resp;
    fcx_hdr_t hdr;
    logic [7:0] rsp_type;
    logic done;
    logic to_cache;
    logic use_cache;
    logic cache_valid;
    logic present_q;
    logic ack;
    logic [31:0] rdata;
    logic err;
  } fcx_top_state_t;

  fcx_top_state_t s, next_s;

  logic [7:0] blk_mem [FCX_BLK_BYTES];
  logic [7:0] cache_mem [FCX_BLK_BYTES];

  fcx_link_t link;
  logic [3:0] link_speed;
  logic start;
  fcx_mrd_t rd_base;
  logic wr_en;
  logic [6:0] wr_idx;
  logic [7:0] wr_data;
  logic rd_done;
  logic rd_timeout;

  fcx_link_calc u_link (
    .cfg(s.lcfg),
    .link_up(port_link_up),
    .link(link),
    .speed(link_speed)
  );

  fcx_xrd #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_xrd (
    .clk(clk),
    .rstn(rstn),
    .start(start),
    .base(rd_base),
    .mod_rd_req(mod_rd_req),
    .mod_rd_addr(mod_rd_addr),
    .mod_rd_ack(mod_rd_ack),
    .mod_rd_data(mod_rd_data),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .done(rd_done),
    .timeout(rd_timeout)
  );

  // Data byte 0 sits in the top byte of the word, as in the packet.
  function automatic logic [31:0] pack_word(input logic [7:0] b0,
                                            input logic [7:0] b1,
                                            input logic [7:0] b2,
                                            input logic [7:0] b3);
    pack_word = {b0, b1, b2, b3};
  endfunction

  function automatic logic is_static(input fcx_req_t r);
    is_static = (r.bank == FCX_STATIC_BANK) && (r.page == FCX_STATIC_PAGE)
      && r.flags[FCX_FLAG_UPPER];
  endfunction

  function automatic fcx_resp_t mk_resp(input logic [15:0] code,
                                        input logic [15:0] reason);
    mk_resp.code = code;
    mk_resp.reason = reason;
  endfunction

  logic acc_rd;
  logic acc_wr;
  logic go;
  logic [4:0] widx;
  logic [31:0] word_blk;
  logic [31:0] word_cache;
  logic [31:0] dec_data;
  logic dec_err;
  fcx_req_t wreq;

  assign widx = paddr[6:2];
  assign word_blk = pack_word(blk_mem[{widx, 2'h0}], blk_mem[{widx, 2'h1}],
    blk_mem[{widx, 2'h2}], blk_mem[{widx, 2'h3}]);
  assign word_cache = pack_word(cache_mem[{widx, 2'h0}],
    cache_mem[{widx, 2'h1}], cache_mem[{widx, 2'h2}],
    cache_mem[{widx, 2'h3}]);

  // Read decode, sampled into a flop on the edge at which pready rises.
  always_comb begin
    dec_data = '0;
    dec_err = 1'b0;
    if (paddr[FCX_DATA_BIT]) begin
      dec_data = s.use_cache ? word_cache : word_blk;
    end else begin
      case (paddr)
        FCX_OFF_CTRL: dec_data = {30'h0, s.nosup, 1'b0};
        FCX_OFF_REQ: dec_data = s.req;
        FCX_OFF_LCFG: dec_data = s.lcfg;
        FCX_OFF_MCFG: dec_data = s.mcfg;
        FCX_OFF_STAT: dec_data = {s.rsp_type, 19'h0, mod_ready, mod_present,
          s.cache_valid, s.done, s.st == M_READ};
        FCX_OFF_RESP: dec_data = s.resp;
        FCX_OFF_HDR: dec_data = s.hdr;
        FCX_OFF_LINK: dec_data = link;
        FCX_OFF_LSPD: dec_data = {28'h0, link_speed};
        default: dec_err = 1'b1;
      endcase
    end
  end

  assign acc_rd = psel && penable && !pwrite && !s.ack;
  assign acc_wr = psel && penable && pwrite && s.ack;
  assign wreq = pwdata;
  assign go = acc_wr && (paddr == FCX_OFF_CTRL) && pwdata[FCX_CTRL_GO]
    && (pwdata[FCX_CTRL_CMD_LSB +: 8] == FCX_CMD_CODE)
    && (s.st == M_IDLE);
  assign rd_base = '{bank: s.req.bank, page: s.req.page,
    offset: s.req.flags[FCX_FLAG_UPPER] ? FCX_UPPER_BASE : 8'h00};

  always_comb begin
    next_s = s;
    start = 1'b0;
    next_s.present_q = mod_present;
    next_s.ack = psel && penable && !s.ack;
    if (acc_rd) begin
      next_s.rdata = dec_data;
      next_s.err = dec_err;
    end else if (psel && penable && pwrite && !s.ack) begin
      next_s.rdata = '0;
      next_s.err = dec_err || paddr[FCX_DATA_BIT];
    end

    // Register writes land on the edge at which pready is high.
    if (acc_wr && s.st == M_IDLE) begin
      case (paddr)
        FCX_OFF_CTRL: next_s.nosup = pwdata[FCX_CTRL_NOSUP];
        FCX_OFF_REQ: next_s.req = wreq;
        FCX_OFF_LCFG: next_s.lcfg = pwdata;
        FCX_OFF_MCFG: next_s.mcfg = pwdata;
        default: ;
      endcase
    end

    // The cached static page goes stale once the module leaves or resets.
    if (!mod_present || !mod_ready || (mod_present && !s.present_q))
      next_s.cache_valid = 1'b0;

    case (s.st)
      M_IDLE: begin
        if (go) begin
          next_s.done = 1'b0;
          next_s.use_cache = 1'b0;
          next_s.rsp_type = FCX_RSP_CODE;
          next_s.hdr.max_bank = s.mcfg.max_bank;
          next_s.hdr.max_page = s.mcfg.max_page;
          next_s.hdr.bank = s.req.bank;
          next_s.hdr.page = s.req.page;
          next_s.to_cache = is_static(s.req);
          if (s.nosup) begin
            next_s.resp = mk_resp(FCX_RSP_UNSUP, FCX_RSN_UNSUP_CMD);
            next_s.done = 1'b1;
          end else if (!mod_present) begin
            next_s.resp = mk_resp(FCX_RSP_UNAVAIL,
              FCX_RSN_NOT_AVAIL);
            next_s.done = 1'b1;
          end else if (!mod_ready) begin
            next_s.resp = mk_resp(FCX_RSP_FAILED,
              FCX_RSN_NOT_AVAIL);
            next_s.done = 1'b1;
          end else if (s.req.bank > s.mcfg.max_bank
              || s.req.page > s.mcfg.max_page) begin
            // A single-bank module has max bank 0, so any other bank fails.
            next_s.resp = mk_resp(FCX_RSP_FAILED,
              FCX_RSN_RANGE);
            next_s.done = 1'b1;
          end else if (is_static(s.req) && s.cache_valid) begin
            next_s.resp = mk_resp(FCX_RSP_OK, FCX_RSN_NONE);
            next_s.use_cache = 1'b1;
            next_s.done = 1'b1;
          end else begin
            start = 1'b1;
            next_s.st = M_READ;
          end
        end
      end
      M_READ: begin
        if (rd_done) begin
          next_s.resp = mk_resp(FCX_RSP_OK, FCX_RSN_NONE);
          next_s.done = 1'b1;
          next_s.st = M_IDLE;
          if (s.to_cache && mod_present && mod_ready)
            next_s.cache_valid = 1'b1;
        end else if (rd_timeout) begin
          next_s.resp = mk_resp(FCX_RSP_FAILED, FCX_RSN_TIMEOUT);
          next_s.done = 1'b1;
          next_s.st = M_IDLE;
        end else if (!mod_present || !mod_ready) begin
          // A pull or reset mid-read waits out the time limit in the reader.
          next_s.to_cache = 1'b0;
        end
      end
      default: next_s.st = M_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  // The block buffer and the static cache fill byte by byte from the reader.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      blk_mem[wr_idx] <= wr_data;
      if (s.to_cache)
        cache_mem[wr_idx] <= wr_data;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ack;
  assign pslverr = s.ack && s.err;

endmodule

// ### dv/fcx_chk.sv
// Assertions on the APB port and the module byte-read handshake.
module fcx_chk import fcx_pkg::*; #(
  parameter int TIMEOUT_CYC = 1000
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic mod_rd_req, // Byte request
  input wire fcx_mrd_t mod_rd_addr, // Byte address
  input wire logic mod_rd_ack // Byte answer
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned req_cyc;
  logic hole;
  // Addresses that are unaligned or lie between the last register and the data words.
  assign hole = paddr[1:0] != 2'b00 || (paddr > 8'h20 && paddr < 8'h80);
  always_ff @(posedge clk) begin
    if (!rstn || !mod_rd_req) begin
      req_cyc <= 0;
    end else begin
      req_cyc <= req_cyc + 1;
    end
  end
  chk_one_wait: assert property (@(posedge clk) disable iff (!rstn)
    psel && !penable |=> !pready ##1 pready) else $error("wrong APB wait");
  chk_ready_pulse: assert property (@(posedge clk) disable iff (!rstn)
    pready |=> !pready) else $error("pready too long");
  chk_ready_cause: assert property (@(posedge clk) disable iff (!rstn)
    pready |-> psel && penable) else $error("pready outside access");
  chk_hole_err: assert property (@(posedge clk) disable iff (!rstn)
    psel && penable && pready && hole |-> pslverr) else $error("no pslverr");
  chk_err_qual: assert property (@(posedge clk) disable iff (!rstn)
    pslverr |-> pready) else $error("pslverr without pready");
  chk_addr_hold: assert property (@(posedge clk) disable iff (!rstn)
    (mod_rd_req && !mod_rd_ack) ##1 mod_rd_req |-> $stable(mod_rd_addr))
    else $error("byte address moved");
  chk_offset_step: assert property (@(posedge clk)
    disable iff (!rstn)
    mod_rd_req && mod_rd_ack && mod_rd_addr.offset[6:0] != 7'h7F |=>
    mod_rd_req && mod_rd_addr.offset == $past(mod_rd_addr.offset) + 8'h01)
    else $error("offset did not step");
  chk_block_end: assert property (@(posedge clk) disable iff (!rstn)
    mod_rd_req && mod_rd_ack && mod_rd_addr.offset[6:0] == 7'h7F |=>
    !mod_rd_req) else $error("request after last byte");
  chk_time_limit: assert property (@(posedge clk)
    disable iff (!rstn) req_cyc <= TIMEOUT_CYC + 1)
    else $error("request outlived limit");
  chk_reset_idle: assert property (@(posedge clk)
    !rstn |=> !pready && !pslverr && !mod_rd_req) else $error("busy in reset");
endmodule

bind fcx_top fcx_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .mod_rd_req(mod_rd_req),
  .mod_rd_addr(mod_rd_addr), .mod_rd_ack(mod_rd_ack));

// ### dv/fcx_mod_model.sv
// Behavioural transceiver module answering byte requests after a delay.
module fcx_mod_model import fcx_pkg::*; (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic req, // Byte request, held until ack
  input wire fcx_mrd_t addr, // Bank, page and offset
  input wire logic mute, // Never answer, to force a time-out
  input wire logic [1:0] lat, // Wait cycles before each answer
  output logic ack, // Answer strobe, one cycle
  output logic [7:0] data // Byte, valid only with ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] waited;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack <= 1'b0;
      waited <= 2'h0;
      data <= 8'h00;
    end else if (req && !ack && !mute && waited >= lat) begin
      ack <= 1'b1;
      data <= addr.offset ^ {addr.bank[3:0], 4'h0} ^ 8'(addr.page * 3);
    end else begin
      // A stale byte is inverted so that a late sample cannot pass.
      ack <= 1'b0;
      waited <= req && !ack ? waited + 2'h1 : 2'h0;
      data <= ~data;
    end
  end
endmodule

// ### dv/tb.sv
// Self-checking bench: link reporting and transceiver block reads.
module tb import fcx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 1000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mod_rd_req, mod_rd_ack, e;
  logic mod_present = 1'b1;
  logic mod_ready = 1'b1;
  logic mute = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [3:0] port_link_up = 4'h0;
  logic [7:0] mod_rd_data;
  fcx_mrd_t mod_rd_addr;
  logic [31:0] seed = 32'h6BCA;
  logic [31:0] q;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int cached = 0;

  fcx_top #(.TIMEOUT_CYC(TMO)) uut (.clk(clk), .rstn(rstn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_link_up(port_link_up), .mod_present(mod_present),
    .mod_ready(mod_ready), .mod_rd_req(mod_rd_req),
    .mod_rd_addr(mod_rd_addr), .mod_rd_ack(mod_rd_ack),
    .mod_rd_data(mod_rd_data));
  fcx_mod_model u_mod (.clk(clk), .rstn(rstn), .req(mod_rd_req),
    .addr(mod_rd_addr), .mute(mute), .lat(lat), .ack(mod_rd_ack),
    .data(mod_rd_data));

  initial forever #25 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] ewd(input int b, input int p, input int o);
    for (int j = 0; j < 4; j++) begin
      ewd[31 - 8 * j -: 8] = 8'((o + j) ^ (b << 4) ^ (p * 3));
    end
  endfunction

  task automatic conclude();
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) cmp("pready", 32'h1, {31'h0, pready});
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    cmp($sformatf("read %h", a), x, q);
    cmp($sformatf("error %h", a), {31'h0, xe}, {31'h0, e});
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    int s, lu, p, c, m, nu, t1, t2, sp, h;
    logic [31:0] x;
    static int lc[6] = '{8'h11, 8'h22, 8'h44, 8'h21, 8'h42, 8'h41};
    static int tc[11][9] = '{'{1, 2, 1, 1, 1, 0, 0, 1, 3},
      '{0, 0, 1, 1, 1, 0, 0, 0, 0},
      '{0, 0, 1, 1, 1, 0, 1, 0, 0}, '{0, 0, 0, 1, 1, 0, 1, 0, 0},
      '{1, 0, 0, 1, 1, 0, 0, 0, 5}, '{0, 6, 0, 1, 1, 0, 0, 0, 5},
      '{0, 5, 0, 1, 1, 0, 0, 0, 5}, '{0, 0, 0, 0, 1, 0, 0, 1, 3},
      '{0, 0, 0, 1, 0, 0, 0, 1, 3}, '{0, 0, 0, 1, 1, 1, 0, 1, 3},
      '{0, 0, 1, 1, 1, 0, 1, 1, 3}};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(FCX_OFF_LCFG, 32'h0, 1'b0);
    rd(FCX_OFF_MCFG, 32'h0, 1'b0);
    rd(FCX_OFF_RESP, 32'h0, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    apb(1'b1, 8'h80, 32'hFFFFFFFF);
    cmp("error 80", 32'h1, {31'h0, e});
    for (int i = 0; i < 6; i++) begin
      p = lc[i] >> 4;
      c = lc[i] & 15;
      m = p / c;
      s = xs() % 9;
      apb(1'b1, FCX_OFF_LCFG, {20'h0, 4'(s), 4'(c), 4'(p)});
      for (int k = 0; k < 2; k++) begin
        lu = xs() % 16;
        port_link_up <= 4'(lu);
        lu = lu & ((1 << p) - 1);
        nu = $countones(4'(lu));
        t1 = m == 4 ? nu : m == 2 ? 2 * $countones(lu[1:0]) : 0;
        t2 = (m == 2 && p == 4) ? 2 * $countones(lu[3:2]) : 0;
        sp = s == 0 ? 0 : s + (m == 4 ? 2 : m == 2 ? 1 : 0);
        if (sp > 8) sp = 8;
        rd(FCX_OFF_LINK, {8'(p), (m > 1 ? 8'((1 << p) - 1) : 8'h00), 8'(lu),
          4'(t2), 4'(t1)}, 1'b0);
        rd(FCX_OFF_LSPD, 32'(sp), 1'b0);
      end
    end
    for (int i = 0; i < 11; i++) begin
      mod_present <= 1'(tc[i][3]);
      mod_ready <= 1'(tc[i][4]);
      mute <= 1'(tc[i][6]);
      lat <= 2'(xs());
      if (tc[i][3] == 0 || tc[i][4] == 0) cached = 0;
      h = tc[i][0] == 0 && tc[i][1] == 0 && tc[i][2] == 1;
      apb(1'b1, FCX_OFF_MCFG, {16'h0, 8'(tc[i][8]), 8'(tc[i][7])});
      apb(1'b1, FCX_OFF_REQ, {8'(tc[i][0]), 8'(tc[i][1]), 8'h00,
        8'(tc[i][2])});
      // The engine looks at the stored reject strap, so it is set before GO.
      apb(1'b1, FCX_OFF_CTRL, {30'h0, 1'(tc[i][5]), 1'b0});
      apb(1'b1, FCX_OFF_CTRL, {16'h0, FCX_CMD_CODE, 6'h0, 1'(tc[i][5]), 1'b1});
      for (int n = 0; n < 400; n++) begin
        apb(1'b0, FCX_OFF_STAT, 32'h0);
        if (q[1] === 1'b1) break;
      end
      cmp("status", 32'hB2000002, q & 32'hFF000003);
      if (tc[i][5] != 0) x = {FCX_RSP_UNSUP, FCX_RSN_UNSUP_CMD};
      else if (tc[i][3] == 0) x = {FCX_RSP_UNAVAIL, FCX_RSN_NOT_AVAIL};
      else if (tc[i][4] == 0) x = {FCX_RSP_FAILED, FCX_RSN_NOT_AVAIL};
      else if (tc[i][0] > tc[i][7] || tc[i][1] > tc[i][8])
        x = {FCX_RSP_FAILED, FCX_RSN_RANGE};
      else if (tc[i][6] != 0 && !(cached != 0 && h != 0))
        x = {FCX_RSP_FAILED, FCX_RSN_TIMEOUT};
      else x = 32'h0;
      rd(FCX_OFF_RESP, x, 1'b0);
      if (x == 32'h0) begin
        if (h != 0) cached = 1;
        rd(FCX_OFF_HDR, {8'(tc[i][7]), 8'(tc[i][8]), 8'(tc[i][0]),
          8'(tc[i][1])}, 1'b0);
        for (int w = 0; w < 32; w++)
          rd(8'h80 + 8'(4 * w), ewd(tc[i][0], tc[i][1], 128 * tc[i][2] + 4 * w),
            1'b0);
      end
    end
    conclude();
  end
endmodule
